// ---- rtl/prcd_decode.sv ----
//==============================================================================
// Reset configuration clock decoder
//==============================================================================
// Purpose: decode PLL fields of the reset configuration word and hold them
// Assumes: cfg inputs and cfg_capture_n_in are synchronous to ref_clk_in
// Notes:   fields are sampled every edge while cfg_capture_n_in is low
//
// Function
// - Core code 0011 with select 0 gives 3:1; VCO divide 4 or 8.
// - Engine PLL factor comes only from multiplication and division fields; the VCO divider has its own field.
// - Engine factor is mult over one plus div; only 2..8 are legal.
// - Engine VCO code 00,01,10 gives 2,4,8; code 11 is reserved.
`timescale 1ns/1ps
`include "prcd_params.svh"

module prcd_decode (
  input  wire logic              ref_clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              cfg_capture_n_in,
  input  wire prcd_pkg::prcd_rcw_t rcw_in,
  output logic [3:0]             core_ratio_out,
  output logic [3:0]             core_vco_div_out,
  output logic [4:0]             engine_mult_out,
  output logic [3:0]             engine_vco_div_out,
  output logic                   core_err_out,
  output logic                   engine_mult_err_out,
  output logic                   engine_vco_err_out,
  output logic                   cfg_error_out,
  output logic                   cfg_valid_out
);
  import prcd_pkg::*;

  //============================================================================
  // Field extraction
  //============================================================================
  logic [0:`PRCD_CORE_W-1] core_field;
  logic [3:0]              core_rat_code;
  logic                    core_sel;
  logic [1:0]              core_vco_code;
  logic [`PRCD_MULT_W-1:0] mult_field;
  logic [`PRCD_DIV_W-1:0]  div_field;
  logic [1:0]              evco_code;

  assign core_field    = rcw_in.core_pll_setting;
  assign core_rat_code = core_field[`PRCD_CORE_RAT_MSB:`PRCD_CORE_RAT_LSB];
  assign core_sel      = core_field[`PRCD_CORE_SEL_BIT];
  assign core_vco_code = core_field[`PRCD_CORE_VCO_MSB:`PRCD_CORE_VCO_LSB];
  // Engine settings look at nothing but these three fields
  assign mult_field    = rcw_in.engine_pll_mult_field;
  assign div_field     = rcw_in.engine_pll_div_field;
  assign evco_code     = rcw_in.engine_vco_div_field;

  //============================================================================
  // Core PLL decode
  //============================================================================
  logic       core_rat_ok;
  logic       core_vco_ok;
  logic [3:0] core_ratio_dec;
  logic [3:0] core_vco_dec;

  // Only the 3:1 row is known; any other ratio code is flagged
  assign core_rat_ok    = (core_rat_code == `PRCD_CORE_RAT_CODE_3) &&
                          (core_sel == `PRCD_CORE_SEL_CODE);
  assign core_ratio_dec = core_rat_ok ? `PRCD_CORE_RATIO_3 : `PRCD_RST_RATIO;

  // Top bits 01 give 4, 10 and 11 give 8; 00 has no defined divider
  assign core_vco_ok  = (core_vco_code == `PRCD_CORE_VCO_01) ||
                        (core_vco_code == `PRCD_CORE_VCO_10) ||
                        (core_vco_code == `PRCD_CORE_VCO_11);
  assign core_vco_dec = (core_vco_code == `PRCD_CORE_VCO_01) ? `PRCD_CORE_DIV_4 :
                        core_vco_ok ? `PRCD_CORE_DIV_8 : `PRCD_RST_DIV;

  // Frequency range of the core VCO is the source's choice; not checkable here
  // because the core clock rate is not known to this block

  //============================================================================
  // Engine PLL decode
  //============================================================================
  logic [`PRCD_MULT_W-1:0] div_plus_one;
  logic [`PRCD_MULT_W-1:0] mult_quot;
  logic                    mult_in_range;
  logic                    mult_ok;
  logic [4:0]              mult_dec;
  logic                    evco_ok;
  logic [3:0]              evco_dec;

  // Division kept general so wider divide fields still decode correctly
  assign div_plus_one  = `PRCD_MULT_W'(div_field) + `PRCD_MULT_W'(1);
  assign mult_quot     = mult_field / div_plus_one;
  assign mult_in_range = (mult_field >= `PRCD_MULT_MIN) &&
                         (mult_field <= `PRCD_MULT_MAX);
  // Nonzero divide codes have no defined rows, so they count as reserved
  assign mult_ok       = mult_in_range && (div_field == `PRCD_DIV_ZERO);
  assign mult_dec      = mult_ok ? mult_quot : `PRCD_RST_MULT;

  assign evco_ok  = (evco_code == `PRCD_EVCO_00) ||
                    (evco_code == `PRCD_EVCO_01) ||
                    (evco_code == `PRCD_EVCO_10);
  assign evco_dec = (evco_code == `PRCD_EVCO_00) ? `PRCD_EVCO_DIV_2 :
                    (evco_code == `PRCD_EVCO_01) ? `PRCD_EVCO_DIV_4 :
                    (evco_code == `PRCD_EVCO_10) ? `PRCD_EVCO_DIV_8 :
                    `PRCD_RST_DIV;

  //============================================================================
  // Capture state
  //============================================================================
  typedef enum logic [1:0] {
    PRCD_ST_CAPTURE = 2'b01,
    PRCD_ST_HOLD    = 2'b10
  } prcd_state_t;

  prcd_state_t state_reg;
  prcd_state_t state_next;
  prcd_cfg_t   cfg_reg;
  prcd_cfg_t   cfg_next;
  prcd_cfg_t   cfg_dec;
  logic        capture;

  //============================================================================
  // Reserved code flags
  //============================================================================
  logic core_err_dec;
  logic mult_err_dec;
  logic evco_err_dec;

  // Unknown core row and missing core VCO divider share one flag
  assign core_err_dec = ~(core_rat_ok & core_vco_ok);
  assign mult_err_dec = ~mult_ok;
  assign evco_err_dec = ~evco_ok;

  assign cfg_dec = '{core_ratio:     core_ratio_dec,
                     core_vco_div:   core_vco_dec,
                     engine_mult:    mult_dec,
                     engine_vco_div: evco_dec,
                     core_err:       core_err_dec,
                     mult_err:       mult_err_dec,
                     evco_err:       evco_err_dec};

  // Capture follows cfg_capture_n_in low; once it goes high the word may change freely
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PRCD_ST_CAPTURE: begin
        if (cfg_capture_n_in) begin
          state_next = PRCD_ST_HOLD;
        end
      end
      PRCD_ST_HOLD: begin
        if (!cfg_capture_n_in) begin
          state_next = PRCD_ST_CAPTURE;
        end
      end
      default: begin
        state_next = PRCD_ST_CAPTURE;
      end
    endcase
  end

  assign capture  = !cfg_capture_n_in;
  assign cfg_next = capture ? cfg_dec : cfg_reg;

  // Async reset loads constants only; the word itself is sampled by the clock
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= PRCD_ST_CAPTURE;
      cfg_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cfg_reg   <= cfg_next;
    end
  end

  //============================================================================
  // Output registers
  //============================================================================
  logic error_next;
  logic valid_next;

  assign error_next = cfg_next.core_err | cfg_next.mult_err | cfg_next.evco_err;
  assign valid_next = (state_next == PRCD_ST_HOLD);

  // Outputs mirror cfg_next so they line up with the held copy
  // Decoded values; reserved codes read as zero here
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_ratio_out      <= `PRCD_RST_RATIO;
      core_vco_div_out    <= `PRCD_RST_DIV;
      engine_mult_out     <= `PRCD_RST_MULT;
      engine_vco_div_out  <= `PRCD_RST_DIV;
    end else begin
      core_ratio_out      <= cfg_next.core_ratio;
      core_vco_div_out    <= cfg_next.core_vco_div;
      engine_mult_out     <= cfg_next.engine_mult;
      engine_vco_div_out  <= cfg_next.engine_vco_div;
    end
  end

  // Flags; errors stay low in reset so a cold part shows no false alarm
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_err_out        <= 1'h0;
      engine_mult_err_out <= 1'h0;
      engine_vco_err_out  <= 1'h0;
      cfg_error_out       <= 1'h0;
      cfg_valid_out       <= 1'h0;
    end else begin
      core_err_out        <= cfg_next.core_err;
      engine_mult_err_out <= cfg_next.mult_err;
      engine_vco_err_out  <= cfg_next.evco_err;
      cfg_error_out       <= error_next;
      cfg_valid_out       <= valid_next;
    end
  end

endmodule

// ---- pkg/prcd_params.svh ----
//==============================================================================
// Constants for the reset configuration clock decoder
//==============================================================================
// Purpose: named field positions, codes and decoded values
// Assumes: bit 0 of each field is its most significant bit
// Notes:   definitions only
`ifndef PRCD_PARAMS_SVH
`define PRCD_PARAMS_SVH

// Core PLL setting field, seven bits numbered 0..6
`define PRCD_CORE_W           7
`define PRCD_CORE_VCO_LSB     1
`define PRCD_CORE_VCO_MSB     0
`define PRCD_CORE_RAT_MSB     2
`define PRCD_CORE_RAT_LSB     5
`define PRCD_CORE_SEL_BIT     6
`define PRCD_CORE_RAT_CODE_3  4'h3
`define PRCD_CORE_SEL_CODE    1'h0
`define PRCD_CORE_RATIO_3     4'h3
`define PRCD_CORE_VCO_01      2'h1
`define PRCD_CORE_VCO_10      2'h2
`define PRCD_CORE_VCO_11      2'h3
`define PRCD_CORE_DIV_4       4'h4
`define PRCD_CORE_DIV_8       4'h8

// Engine PLL fields
`define PRCD_MULT_W           5
`define PRCD_DIV_W            1
`define PRCD_MULT_MIN         5'h02
`define PRCD_MULT_MAX         5'h08
`define PRCD_DIV_ZERO         1'h0
`define PRCD_EVCO_00          2'h0
`define PRCD_EVCO_01          2'h1
`define PRCD_EVCO_10          2'h2
`define PRCD_EVCO_DIV_2       4'h2
`define PRCD_EVCO_DIV_4       4'h4
`define PRCD_EVCO_DIV_8       4'h8

// Reset values of the held outputs
`define PRCD_RST_RATIO        4'h0
`define PRCD_RST_DIV          4'h0
`define PRCD_RST_MULT         5'h00

`endif

// ---- pkg/prcd_pkg.sv ----
//==============================================================================
// Types for the reset configuration clock decoder
//==============================================================================
// Purpose: carriers for the configuration fields and decoded settings
// Assumes: prcd_params.svh gives the field widths
// Notes:   bit 0 is the most significant bit of each field
`include "prcd_params.svh"

package prcd_pkg;

  // Clock fields of the low reset configuration word
  typedef struct packed {
    logic [0:`PRCD_CORE_W-1] core_pll_setting;
    logic [0:`PRCD_MULT_W-1] engine_pll_mult_field;
    logic [0:`PRCD_DIV_W-1]  engine_pll_div_field;
    logic [0:1]              engine_vco_div_field;
  } prcd_rcw_t;

  // Decoded clock settings and error flags
  typedef struct packed {
    logic [3:0] core_ratio;
    logic [3:0] core_vco_div;
    logic [4:0] engine_mult;
    logic [3:0] engine_vco_div;
    logic       core_err;
    logic       mult_err;
    logic       evco_err;
  } prcd_cfg_t;

endpackage

// ---- tb/prcd_rcw_src.sv ----
//==============================================================================
// Reset configuration word source
//==============================================================================
// Purpose: supplies the word and the capture window at power-up
// Assumes: bench asks for a window with req_in
// Notes:   window held low across reset release
`timescale 1ns/1ps
module prcd_rcw_src (
  input  wire logic                ref_clk_in,
  input  wire logic                arst_n_in,
  input  wire logic                req_in,
  input  wire prcd_pkg::prcd_rcw_t word_in,
  output logic                     cap_n_out,
  output prcd_pkg::prcd_rcw_t      rcw_out
);
  import prcd_pkg::*;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cap_n_out <= 1'h0;
      rcw_out   <= word_in;
    end else begin
      cap_n_out <= ~req_in;
      // Word not held outside the window, so a stale capture shows
      rcw_out   <= req_in ? word_in : ~rcw_out;
    end
  end
endmodule

// ---- tb/prcd_decode_chk.sv ----
//==============================================================================
// Decoder checker
//==============================================================================
// Purpose: timing and decode relations at the decoder ports
// Assumes: one clock domain
// Notes:   bound into every decoder instance
`timescale 1ns/1ps
module prcd_decode_chk (
  input wire logic                ref_clk_in,
  input wire logic                arst_n_in,
  input wire logic                cfg_capture_n_in,
  input wire prcd_pkg::prcd_rcw_t rcw_in,
  input wire logic [3:0]          core_ratio_out,
  input wire logic [3:0]          core_vco_div_out,
  input wire logic [4:0]          engine_mult_out,
  input wire logic [3:0]          engine_vco_div_out,
  input wire logic                core_err_out,
  input wire logic                engine_mult_err_out,
  input wire logic                engine_vco_err_out,
  input wire logic                cfg_error_out,
  input wire logic                cfg_valid_out
);
  import prcd_pkg::*;
  wire logic cap = !cfg_capture_n_in;
  wire logic r_ok = rcw_in.core_pll_setting[2:6] == 5'h06;
  wire logic m_ok = rcw_in.engine_pll_mult_field inside {[5'h02:5'h08]}
                    && rcw_in.engine_pll_div_field == 1'h0;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  hold_closed_a: assert property (!cap |=> cfg_valid_out && $stable({core_ratio_out,
    core_vco_div_out, engine_mult_out, engine_vco_div_out, cfg_error_out})) else $error("moved");
  open_valid_a: assert property (cap |=> !cfg_valid_out) else $error("valid in window");
  core_ratio_a: assert property (cap |=> core_ratio_out == ($past(r_ok) ? 4'h3 : 4'h0))
    else $error("core ratio");
  core_vco_a: assert property (cap |=> core_vco_div_out == ($past(rcw_in.core_pll_setting[0:1])
    == 2'h1 ? 4'h4 : ($past(rcw_in.core_pll_setting[0:1]) == 2'h0 ? 4'h0 : 4'h8)))
    else $error("core vco divider");
  core_err_a: assert property (cap |=> core_err_out != ($past(r_ok)
    && $past(rcw_in.core_pll_setting[0:1]) != 2'h0)) else $error("core error");
  eng_mult_a: assert property (cap |=> engine_mult_out == ($past(m_ok)
    ? $past(rcw_in.engine_pll_mult_field) : 5'h00) && engine_mult_err_out != $past(m_ok))
    else $error("engine factor");
  eng_vco_a: assert property (cap |=> engine_vco_div_out ==
    (4'h2 << $past(rcw_in.engine_vco_div_field))) else $error("engine vco divider");
  eng_vco_err_a: assert property (cap |=> engine_vco_err_out ==
    ($past(rcw_in.engine_vco_div_field) == 2'h3)) else $error("engine vco error");
  err_or_a: assert property (cfg_error_out ==
    (core_err_out | engine_mult_err_out | engine_vco_err_out)) else $error("error summary");
endmodule

bind prcd_decode prcd_decode_chk u_chk (.*);

// ---- tb/test_prcd_decode.sv ----
//==============================================================================
// Decoder testbench
//==============================================================================
// Purpose: captures words through the source model and checks decodes
// Assumes: 50 MHz clock
// Notes:   expectations worked out locally
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module test_prcd_decode;
  import prcd_pkg::*;
  logic      clk = 1'h0, arst_n = 1'h0, req = 1'h0, cap_n;
  prcd_rcw_t word = 15'h4C4A, rcw, w;
  prcd_cfg_t got;
  logic      err, vld;
  int        n_mismatch = 0, num_checks = 0, cyc = 0;
  prcd_rcw_src src (.ref_clk_in(clk), .arst_n_in(arst_n), .req_in(req), .word_in(word),
                    .cap_n_out(cap_n), .rcw_out(rcw));
  prcd_decode dut (.ref_clk_in(clk), .arst_n_in(arst_n), .cfg_capture_n_in(cap_n),
    .rcw_in(rcw), .core_ratio_out(got.core_ratio), .core_vco_div_out(got.core_vco_div),
    .engine_mult_out(got.engine_mult), .engine_vco_div_out(got.engine_vco_div),
    .core_err_out(got.core_err), .engine_mult_err_out(got.mult_err),
    .engine_vco_err_out(got.evco_err), .cfg_error_out(err), .cfg_valid_out(vld));
  initial forever #10 clk = ~clk;
  function automatic prcd_cfg_t exp_of(input prcd_rcw_t x);
    prcd_cfg_t e;
    logic      ok;
    ok = x.engine_pll_mult_field inside {[5'h02:5'h08]} && x.engine_pll_div_field == 1'h0;
    e.core_ratio = (x.core_pll_setting[2:6] == 5'h06) ? 4'h3 : 4'h0;
    e.core_vco_div = x.core_pll_setting[0:1] == 2'h1 ? 4'h4 :
                     (x.core_pll_setting[0:1] == 2'h0 ? 4'h0 : 4'h8);
    e.core_err = e.core_ratio == 4'h0 || e.core_vco_div == 4'h0;
    e.engine_mult = ok ? x.engine_pll_mult_field : 5'h00;
    e.mult_err = !ok;
    e.engine_vco_div = x.engine_vco_div_field == 2'h3 ? 4'h0 : 4'h2 << x.engine_vco_div_field;
    e.evco_err = x.engine_vco_div_field == 2'h3;
    return e;
  endfunction
  task automatic chk_word(input prcd_rcw_t x);
    prcd_cfg_t e;
    e = exp_of(x);
    `CHK("decoded", e, got)
    `CHK("cfg_error", e.core_err | e.mult_err | e.evco_err, err)
    `CHK("cfg_valid", 1'h1, vld)
  endtask
  // Second word lands one edge after the first: last one must win
  task automatic cap(input prcd_rcw_t a, input prcd_rcw_t b);
    @(posedge clk);
    req <= 1'h1;
    word <= a;
    @(posedge clk);
    word <= b;
    @(posedge clk);
    req <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    #1;
    `CHK("reset outputs", 22'h0, {got, err, vld})
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk_word(15'h4C4A);
    $display("test reset capture done");
    for (int i = 0; i < 32; i++) begin
      w = {i[3:2], (i == 7) ? 5'h07 : 5'h06, i[4:0], i == 20, i[1:0]};
      cap(w, w);
      chk_word(w);
    end
    $display("test code sweep done");
    cap(15'h7FFF, 15'h4C4A);
    chk_word(15'h4C4A);
    repeat (10) @(posedge clk);
    #1;
    chk_word(15'h4C4A);
    $display("test back to back and hold done");
    @(posedge clk);
    arst_n <= 1'h0;
    #1;
    `CHK("mid reset", 22'h0, {got, err, vld})
    $display("test mid reset done");
    give_verdict();
  end
endmodule
